// file: include/nfc_defs.vh
/*
 * Constants for the NAND unique-ID and feature command controller.
 * Assumes a single 50 MHz clock and an asynchronous NAND target on pins.
 */
// Overview of operation
// [RULE1] Unique-ID read command EDh is accepted only while every die is idle.
// [RULE2] After EDh the target stays in unique-ID mode until another command.
// [RULE3] EDh is followed by one 00h address; target busy for page read time.
// [RULE4] After polling with 70h, host issues 00h to re-enable data output.
// [RULE5] One identifier byte is output per read-enable toggle.
// [RULE6] Sixteen identifier copies of 32 bytes; first 16 bytes are data.
// [RULE7] Bytes 16 to 31 of each copy are the complement of bytes 0 to 15.
// [RULE8] Host XORs halves; copy valid when all 16 results equal FFh.
// [RULE9] Host may reposition output column with 05h then E0h.
// [RULE10] On x16 parts the upper eight data lines are ignored.
// [RULE11] EFh writes, EEh reads four parameter bytes at a one-byte address.
// [RULE12] Feature settings are volatile and survive a reset command FFh.
// [RULE13] Host may issue feature commands after the initial reset.
// [RULE14] ECC setup: EFh, address 90h, parameters; only first byte used.
// [RULE15] Parameter 08h enables ECC, 00h disables; wait feature busy time.
// [RULE16] Feature addresses 01h, 80h, 81h, 90h defined; others reserved.
// [RULE17] Array operation mode returns to 00h on power cycle.
// [RULE18] Parameter page read, program, erase times low byte first.
// [RULE19] Parameter page bytes 256-767 repeat bytes 0-255.
// [RULE20] After four set parameters target is busy for feature busy time.
// [RULE21] Host waits address-to-data delay, one parameter per write edge.
// [RULE22] Host never sets reserved addresses; reserved bytes driven zero.
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH
// ==========================================================
// Register map
`define NFC_REG_CTRL 12'h000
`define NFC_REG_STAT 12'h004
`define NFC_REG_FADDR 12'h008
`define NFC_REG_PARAM 12'h00C
`define NFC_REG_RDATA 12'h010
`define NFC_REG_UIDOK 12'h014
// ==========================================================
// Control fields
`define NFC_CTRL_GO 0
`define NFC_OP_LSB 1
`define NFC_OP_MSB 3
`define NFC_OP_UID 3'h0
`define NFC_OP_SETF 3'h1
`define NFC_OP_GETF 3'h2
`define NFC_OP_RESET 3'h3
`define NFC_OP_RDPP 3'h4
`define NFC_OP_RDBYTE 3'h5
`define NFC_OP_COLCHG 3'h6
// ==========================================================
// Commands and addresses
`define NFC_CMD_UID 8'hED
`define NFC_CMD_SETF 8'hEF
`define NFC_CMD_GETF 8'hEE
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_READMODE 8'h00
`define NFC_CMD_COL1 8'h05
`define NFC_CMD_COL2 8'hE0
`define NFC_CMD_RESET 8'hFF
`define NFC_CMD_PARAM 8'hEC
`define NFC_ADDR_ZERO 8'h00
`define NFC_FA_TIMING 8'h01
`define NFC_FA_DRIVE 8'h80
`define NFC_FA_PULLDN 8'h81
`define NFC_FA_ARRAY 8'h90
`define NFC_ECC_ON 8'h08
`define NFC_ECC_OFF 8'h00
`define NFC_XOR_OK 8'hFF
`define NFC_UID_HALF 5'h10
`define NFC_UID_COPY 6'h20
// ==========================================================
// Timing in ns and cycles at 20 ns
`define NFC_CLK_NS 20
`define NFC_T_STROBE_NS 40
`define NFC_T_ADL_NS 100
`define NFC_T_CCS_NS 100
`define NFC_T_STROBE_CYC ((`NFC_T_STROBE_NS+`NFC_CLK_NS-1)/`NFC_CLK_NS)
`define NFC_T_ADL_CYC ((`NFC_T_ADL_NS+`NFC_CLK_NS-1)/`NFC_CLK_NS)
`define NFC_T_CCS_CYC ((`NFC_T_CCS_NS+`NFC_CLK_NS-1)/`NFC_CLK_NS)
`define NFC_STATUS_RDY 6
`endif

// file: hw/nfc_sync.v
/*
 * Two-flop synchroniser for a pin level.
 * Assumes presetn async low and pclk domain.
 */
`timescale 1ns/100ps
module nfc_sync (
    pclk,
    presetn,
    d,
    q
);
input wire pclk;
input wire presetn;
input wire d;
output reg q;
reg meta_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        // Idle level of a pulled-up pin, so no false busy after reset
        meta_q <= 1'b1;
        q <= 1'b1;
    end else begin
        meta_q <= d;
        q <= meta_q;
    end
end
endmodule // nfc_sync

// file: hw/nfc_ctrl.v
/*
 * APB-controlled host sequencer for NAND unique-ID and feature commands.
 * Assumes an asynchronous x8 or x16 NAND target on the pins and 50 MHz pclk.
 */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "nfc_defs.vh"
module nfc_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg nand_cle,
    output reg nand_ale,
    output reg nand_we_n,
    output reg nand_re_n,
    output reg nand_ce_n,
    output reg [7:0] nand_dq_o,
    output reg nand_dq_oe,
    input wire [15:0] nand_dq_i,
    input wire ready_busy_pin
);
// ==========================================================
// State codes
localparam S_IDLE = 4'h0;
localparam S_CMD = 4'h1;
localparam S_ADDR = 4'h2;
localparam S_DLY = 4'h3;
localparam S_WDAT = 4'h4;
localparam S_BUSY = 4'h5;
localparam S_RDAT = 4'h6;
localparam S_CMD2 = 4'h7;
localparam S_DONE = 4'h8;
localparam S_POLL = 4'h9;
localparam S_PRD = 4'hA;

reg [3:0] st_q;
reg [3:0] cnt_q;
reg [1:0] idx_q;
reg [2:0] op_q;
reg [7:0] faddr_q;
reg [31:0] param_q;
reg [31:0] rdata_q;
reg [7:0] col_q;
reg [15:0] uidok_q;
reg [4:0] bcnt_q;
reg [3:0] copy_q;
reg [7:0] half_q [0:15];
reg all_ok_q;
reg busy_q;
reg seen_busy_q;
reg err_q;
wire rb_s;
wire [7:0] din = nand_dq_i[7:0]; // Upper byte ignored, see [RULE10]
wire wr_en = psel & penable & pwrite;
wire pwpick_go = pwdata[`NFC_CTRL_GO];
wire ctrl_go = wr_en && paddr == `NFC_REG_CTRL && pwpick_go;
wire [2:0] wop = pwdata[`NFC_OP_MSB:`NFC_OP_LSB];
wire strobe_done = cnt_q == `NFC_T_STROBE_CYC;
integer i;

nfc_sync u_rb (
    .pclk(pclk),
    .presetn(presetn),
    .d(ready_busy_pin),
    .q(rb_s)
);

assign pready = 1'b1;
assign pslverr = psel & penable & ~(paddr == `NFC_REG_CTRL ||
    paddr == `NFC_REG_STAT || paddr == `NFC_REG_FADDR ||
    paddr == `NFC_REG_PARAM || paddr == `NFC_REG_RDATA ||
    paddr == `NFC_REG_UIDOK);

// ==========================================================
// Register reads
always @* begin
    case (paddr)
        `NFC_REG_STAT: prdata = {29'h0, err_q, rb_s, busy_q};
        `NFC_REG_FADDR: prdata = {24'h0, faddr_q};
        `NFC_REG_PARAM: prdata = param_q;
        `NFC_REG_RDATA: prdata = rdata_q;
        `NFC_REG_UIDOK: prdata = {16'h0, uidok_q};
        default: prdata = 32'h0;
    endcase
end

// ==========================================================
// Sequencer
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_q <= S_IDLE;
        cnt_q <= 4'h0;
        idx_q <= 2'h0;
        op_q <= 3'h0;
        faddr_q <= 8'h0;
        param_q <= 32'h0;
        rdata_q <= 32'h0;
        col_q <= 8'h0;
        uidok_q <= 16'h0;
        bcnt_q <= 5'h0;
        copy_q <= 4'h0;
        all_ok_q <= 1'b1;
        busy_q <= 1'b0;
        seen_busy_q <= 1'b0;
        err_q <= 1'b0;
        nand_cle <= 1'b0;
        nand_ale <= 1'b0;
        nand_we_n <= 1'b1;
        nand_re_n <= 1'b1;
        nand_ce_n <= 1'b1;
        nand_dq_o <= 8'h0;
        nand_dq_oe <= 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
            half_q[i] <= 8'h0;
        end
    end else begin
        // Features may be configured while no order is busy (busy_q low), see [RULE13]
        if (wr_en && paddr == `NFC_REG_FADDR && !busy_q) begin
            faddr_q <= pwdata[7:0];
        end
        if (wr_en && paddr == `NFC_REG_PARAM && !busy_q) begin
            param_q <= pwdata;
        end
        case (st_q)
            S_IDLE: begin
                nand_ce_n <= 1'b1;
                if (ctrl_go && !busy_q) begin
                    // Refuse while the die is busy, see [RULE1]
                    if (!rb_s || (wop == `NFC_OP_SETF &&
                        !(faddr_q == `NFC_FA_TIMING ||
                        faddr_q == `NFC_FA_DRIVE ||
                        faddr_q == `NFC_FA_PULLDN ||
                        faddr_q == `NFC_FA_ARRAY))) begin
                        err_q <= 1'b1; // see [RULE16] [RULE22]
                    end else begin
                        err_q <= 1'b0;
                        busy_q <= 1'b1;
                        op_q <= wop;
                        nand_ce_n <= 1'b0;
                        st_q <= S_CMD;
                        cnt_q <= 4'h0;
                        bcnt_q <= 5'h0;
                        idx_q <= 2'h0;
                        if (wop == `NFC_OP_UID) begin
                            uidok_q <= 16'h0;
                            copy_q <= 4'h0;
                            all_ok_q <= 1'b1;
                        end
                        case (wop)
                            `NFC_OP_UID: nand_dq_o <= `NFC_CMD_UID;
                            `NFC_OP_SETF: nand_dq_o <= `NFC_CMD_SETF;
                            `NFC_OP_GETF: nand_dq_o <= `NFC_CMD_GETF;
                            `NFC_OP_RESET: nand_dq_o <= `NFC_CMD_RESET;
                            `NFC_OP_RDPP: nand_dq_o <= `NFC_CMD_PARAM;
                            `NFC_OP_COLCHG: begin
                                nand_dq_o <= `NFC_CMD_COL1; // see [RULE9]
                                col_q <= pwdata[15:8];
                            end
                            default: nand_dq_o <= `NFC_CMD_READMODE;
                        endcase
                        if (wop == `NFC_OP_RDBYTE) begin
                            st_q <= S_RDAT;
                        end
                    end
                end
            end
            S_CMD, S_ADDR, S_WDAT, S_CMD2, S_POLL: begin
                // Latch on the rising write edge, then hold one cycle
                nand_cle <= (st_q == S_CMD) || (st_q == S_CMD2) ||
                    (st_q == S_POLL);
                nand_ale <= (st_q == S_ADDR);
                nand_dq_oe <= 1'b1;
                nand_we_n <= (cnt_q >= `NFC_T_STROBE_CYC);
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `NFC_T_STROBE_CYC + 1) begin
                    cnt_q <= 4'h0;
                    nand_cle <= 1'b0;
                    nand_ale <= 1'b0;
                    nand_dq_oe <= 1'b0;
                    if (st_q == S_CMD && op_q == `NFC_OP_RESET) begin
                        st_q <= S_BUSY; // features kept, see [RULE12]
                    end else if (st_q == S_CMD && op_q == `NFC_OP_COLCHG) begin
                        st_q <= S_ADDR;
                        nand_dq_o <= col_q;
                    end else if (st_q == S_CMD) begin
                        st_q <= S_ADDR; // see [RULE3] [RULE11]
                        nand_dq_o <= (op_q == `NFC_OP_SETF ||
                            op_q == `NFC_OP_GETF) ? faddr_q : `NFC_ADDR_ZERO;
                    end else if (st_q == S_ADDR && op_q == `NFC_OP_COLCHG) begin
                        st_q <= S_CMD2;
                        nand_dq_o <= `NFC_CMD_COL2;
                    end else if (st_q == S_ADDR && op_q == `NFC_OP_SETF) begin
                        st_q <= S_DLY;
                    end else if (st_q == S_ADDR) begin
                        st_q <= S_BUSY;
                    end else if (st_q == S_POLL) begin
                        // Status cycle done, read mode next, see [RULE4]
                        st_q <= S_CMD2;
                        nand_dq_o <= `NFC_CMD_READMODE;
                    end else if (st_q == S_CMD2 && op_q == `NFC_OP_COLCHG) begin
                        st_q <= S_DLY;
                    end else if (st_q == S_CMD2) begin
                        st_q <= S_RDAT; // Output re-enabled, see [RULE4]
                    end else if (idx_q == 2'h3) begin
                        st_q <= S_BUSY; // see [RULE20]
                    end else begin
                        idx_q <= idx_q + 2'h1;
                        nand_dq_o <= param_q[8*(idx_q+1) +: 8];
                    end
                end
            end
            S_DLY: begin
                // Address-to-data gap before parameters, see [RULE21]
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `NFC_T_ADL_CYC) begin
                    cnt_q <= 4'h0;
                    if (op_q == `NFC_OP_COLCHG) begin
                        st_q <= S_DONE;
                    end else begin
                        st_q <= S_WDAT; // see [RULE14] [RULE15]
                        nand_dq_o <= param_q[7:0];
                    end
                end
            end
            S_BUSY: begin
                // Wait for busy to appear or the count to saturate at 15, then ready
                if (!rb_s) begin
                    seen_busy_q <= 1'b1;
                end
                cnt_q <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
                if (rb_s && (seen_busy_q || cnt_q == 4'hF)) begin
                    seen_busy_q <= 1'b0;
                    cnt_q <= 4'h0;
                    idx_q <= 2'h0;
                    if (op_q == `NFC_OP_UID || op_q == `NFC_OP_GETF) begin
                        st_q <= S_POLL;
                        nand_dq_o <= `NFC_CMD_STATUS;
                    end else if (op_q == `NFC_OP_RDPP) begin
                        st_q <= S_RDAT;
                    end else begin
                        st_q <= S_DONE;
                    end
                end
            end
            S_RDAT: begin
                // One byte per read toggle, see [RULE5]
                nand_re_n <= (cnt_q >= `NFC_T_STROBE_CYC);
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `NFC_T_STROBE_CYC - 1) begin
                    rdata_q <= {rdata_q[23:0], din};
                end
                if (cnt_q == `NFC_T_STROBE_CYC + 1) begin
                    cnt_q <= 4'h0;
                    st_q <= S_PRD;
                end
            end
            S_PRD: begin
                st_q <= S_DONE;
                if (op_q == `NFC_OP_UID) begin
                    // Check copies: complement halves, see [RULE6] [RULE7]
                    bcnt_q <= bcnt_q + 5'h1;
                    if (bcnt_q < `NFC_UID_HALF) begin
                        half_q[bcnt_q[3:0]] <= din;
                    end else if ((half_q[bcnt_q[3:0]] ^ din) != `NFC_XOR_OK) begin
                        all_ok_q <= 1'b0; // see [RULE8]
                    end
                    if (bcnt_q == 5'h1F) begin
                        uidok_q[copy_q] <= all_ok_q &&
                            ((half_q[4'hF] ^ din) == `NFC_XOR_OK);
                        copy_q <= copy_q + 4'h1;
                        all_ok_q <= 1'b1;
                    end
                    st_q <= (bcnt_q == 5'h1F) ? S_DONE : S_RDAT;
                end else if (op_q == `NFC_OP_GETF || op_q == `NFC_OP_RDPP) begin
                    idx_q <= idx_q + 2'h1;
                    if (idx_q != 2'h3) begin
                        st_q <= S_RDAT;
                    end
                end
            end
            S_DONE: begin
                busy_q <= 1'b0;
                st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
        endcase
    end
end
endmodule // nfc_ctrl

// file: test/nfc_ctrl_props.sv
/* Checker on the NAND pins of nfc_ctrl.
   Assumes one pclk domain; it is bound to nfc_ctrl below. */
`timescale 1ns/100ps
module nfc_ctrl_props (
    input wire pclk,
    input wire presetn,
    input wire nand_cle,
    input wire nand_ale,
    input wire nand_we_n,
    input wire nand_re_n,
    input wire nand_ce_n,
    input wire [7:0] nand_dq_o,
    input wire nand_dq_oe,
    input wire ready_busy_pin
);
// ==========
// Cycle latched by the last write strobe
reg wlow_q, wcle_q, wale_q;
reg [7:0] wdat_q, cmd_q;
wire latch_ev = nand_we_n && wlow_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {wlow_q, wcle_q, wale_q, wdat_q, cmd_q} <= 19'h0;
    end else begin
        wlow_q <= !nand_we_n;
        if (!nand_we_n) begin
            wcle_q <= nand_cle;
            wale_q <= nand_ale;
            wdat_q <= nand_dq_o;
        end
        if (latch_ev && wcle_q) begin
            cmd_q <= wdat_q;
        end
    end
end
wire addr_ev = latch_ev && wale_q;
// ==========
// Pin protocol
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
reset_idle_a: assert property (
    $rose(presetn) |-> nand_ce_n && nand_we_n && nand_re_n && !nand_dq_oe)
    else $error("pins not idle after reset");
we_width_a: assert property (
    $fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n)
    else $error("write strobe not two cycles");
we_drive_a: assert property (
    !nand_we_n |-> nand_dq_oe && !nand_ce_n)
    else $error("write strobe without driven data");
re_quiet_a: assert property (
    !nand_re_n |-> !nand_dq_oe && nand_we_n && ready_busy_pin)
    else $error("read strobe while driving or busy");
dq_hold_a: assert property (
    !nand_we_n && !$past(nand_we_n) |-> $stable(nand_dq_o) && $stable(nand_cle))
    else $error("data moved during write strobe");
uid_addr_a: assert property (
    addr_ev && cmd_q == 8'hED |-> wdat_q == 8'h00)
    else $error("unique id address not zero");
feat_addr_a: assert property (
    addr_ev && cmd_q == 8'hEF |-> wdat_q inside {8'h01, 8'h80, 8'h81, 8'h90})
    else $error("set feature to reserved address");
adl_gap_a: assert property (
    addr_ev && cmd_q == 8'hEF |-> nand_we_n [*3])
    else $error("parameter too soon after address");
cover property (addr_ev && cmd_q == 8'hED);
cover property (addr_ev && cmd_q == 8'hEF && wdat_q == 8'h90);
cover property ($fell(nand_re_n));
endmodule // nfc_ctrl_props
bind nfc_ctrl nfc_ctrl_props props_u (.pclk(pclk), .presetn(presetn),
    .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
    .nand_re_n(nand_re_n), .nand_ce_n(nand_ce_n), .nand_dq_o(nand_dq_o),
    .nand_dq_oe(nand_dq_oe), .ready_busy_pin(ready_busy_pin));

// file: test/nfc_nand_model.sv
/* Behavioural NAND target: unique ID, features, parameter page.
   Assumes host pins of nfc_ctrl; busy time is a plain delay. */
`timescale 1ns/100ps
module nfc_nand_model #(
    parameter BUSY_NS = 300
) (
    input wire cle,
    input wire ale,
    input wire we_n,
    input wire re_n,
    input wire ce_n,
    input wire [7:0] din,
    input wire bad_uid,
    input wire hold_busy,
    output reg [15:0] dq,
    output wire rb
);
// ==========
// State
localparam [63:0] TIMES = 64'h5802B80B19006400;
reg rdy_q = 1'b1;
reg stat_q = 1'b0;
reg [7:0] mode_q = 8'h00;
reg [7:0] last_q, fa_q;
reg [15:0] col_q, ncol_q;
reg [31:0] feat_q [0:255];
integer n_q, j;
event busy_e;
assign rb = rdy_q && !hold_busy;
function [7:0] uid(input [4:0] c);
    uid = c[3:0] * 8'h1D + 8'h03;
    if (c[4]) uid = ~uid;
    if (bad_uid && c == 5'd20) uid = uid ^ 8'h10;
endfunction
initial begin
    dq = 16'h0000;
    for (j = 0; j < 256; j = j + 1) feat_q[j] = 32'h0;
end
always @(busy_e) begin
    rdy_q = 1'b0;
    #(BUSY_NS) rdy_q = 1'b1;
end
// ==========
// Cycles, sampled mid-strobe so pin skew cannot race
always @(negedge we_n) begin
    #10;
    if (!ce_n && cle && (rdy_q || din == 8'h70)) begin
        stat_q = (din == 8'h70);
        if (din == 8'hE0) col_q = ncol_q;
        if (din == 8'h05) n_q = 0;
        if (din != 8'h70 && din != 8'h00 && din[7:4] != 4'h0 && din != 8'hE0) begin
            mode_q = din;
            n_q = 0;
            col_q = 16'h0;
        end
        if (din == 8'hFF) -> busy_e;
        last_q = din;
    end else if (!ce_n && ale && last_q == 8'h05) begin
        ncol_q = (n_q == 0) ? {8'h0, din} : {din, ncol_q[7:0]};
        n_q = n_q + 1;
    end else if (!ce_n && ale) begin
        fa_q = din;
        if (mode_q != 8'hEF) -> busy_e;
    end else if (!ce_n && mode_q == 8'hEF && n_q < 4) begin
        feat_q[fa_q][8*n_q +: 8] = (fa_q == 8'h90 && n_q > 0) ? 8'h0 : din;
        n_q = n_q + 1;
        if (n_q == 4) -> busy_e;
    end
end
always @(negedge re_n) if (!ce_n) begin
    if (stat_q) dq[7:0] = {1'b0, rdy_q, 6'h00};
    else if (mode_q == 8'hED) dq[7:0] = uid(col_q[4:0]);
    else if (mode_q == 8'hEE) dq[7:0] = feat_q[fa_q][8*col_q[1:0] +: 8];
    else if (col_q[7:0] >= 133 && col_q[7:0] <= 140)
        dq[7:0] = TIMES[8*(140-col_q[7:0]) +: 8];
    else dq[7:0] = col_q[7:0] ^ 8'h5A;
    dq[15:8] = ~dq[15:8] ^ col_q[7:0];
    if (!stat_q) col_q = col_q + 16'h1;
end
// Deselected target no longer shows its last byte
always @(posedge ce_n) dq = ~dq;
endmodule // nfc_nand_model

// file: test/testbench.sv
/* Bench for nfc_ctrl against the behavioural NAND target.
   Assumes nfc_defs.vh on the include path. */
`timescale 1ns/100ps
`include "nfc_defs.vh"
module testbench;
reg pclk, presetn, psel, penable, pwrite, s, bad_uid, hold_busy;
reg [11:0] paddr;
reg [31:0] pwdata, r, e, seed_q;
reg [7:0] fa, p1;
integer n_errors, compares, i, k;
wire [31:0] prdata;
wire pready, pslverr, cle, ale, we_n, re_n, ce_n, oe, rb;
wire [7:0] dq_o;
wire [15:0] dq_i;
nfc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_cle(cle),
    .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_ce_n(ce_n),
    .nand_dq_o(dq_o), .nand_dq_oe(oe), .nand_dq_i(dq_i),
    .ready_busy_pin(rb));
nfc_nand_model nand_u (.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .ce_n(ce_n), .din(dq_o), .bad_uid(bad_uid), .hold_busy(hold_busy),
    .dq(dq_i), .rb(rb));
initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end
// ==========
// Helpers
function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function [7:0] uidb(input [3:0] c);
    uidb = c * 8'h1D + 8'h03;
endfunction
task report_and_stop;
    begin
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    end
endtask
task chk(input [31:0] x, input [31:0] g, input [8*8:1] nm);
    begin
        compares = compares + 1;
        if (g !== x) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s exp %h got %h", nm, x, g);
        end
    end
endtask
// Read data and error are taken on the completing edge
task apb(input w, input [11:0] a, input [31:0] d);
    reg rdy;
    integer t;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        rdy = 1'b0;
        for (t = 0; t < 50 && !rdy; t = t + 1) begin
            @(posedge pclk);
            rdy = (pready === 1'b1);
            r = prdata;
            s = pslverr;
        end
        if (!rdy) n_errors = n_errors + 1;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
// Starts an order, polls busy, leaves the read shift register in r
task op(input [2:0] o, input [7:0] c);
    integer t;
    begin
        apb(1'b1, `NFC_REG_CTRL, {16'h0, c, 4'h0, o, 1'b1});
        r = 32'h1;
        for (t = 0; t < 500 && r[0] !== 1'b0; t = t + 1)
            apb(1'b0, `NFC_REG_STAT, 32'h0);
        if (r[0] !== 1'b0) n_errors = n_errors + 1;
        apb(1'b0, `NFC_REG_RDATA, 32'h0);
    end
endtask
// ==========
// Scenarios
initial begin
    n_errors = 0;
    compares = 0;
    seed_q = 32'hAE28;
    {presetn, psel, penable, pwrite, bad_uid, hold_busy} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    op(`NFC_OP_UID, 8'h00);
    chk({~uidb(12), ~uidb(13), ~uidb(14), ~uidb(15)}, r, "uid");
    apb(1'b0, `NFC_REG_UIDOK, 32'h0);
    chk(32'h1, r & 32'h1, "uidok");
    bad_uid <= 1'b1;
    op(`NFC_OP_UID, 8'h00);
    apb(1'b0, `NFC_REG_UIDOK, 32'h0);
    chk(32'h0, r & 32'h1, "uidbad");
    bad_uid <= 1'b0;
    $display("uid test done");
    for (i = 0; i < 5; i = i + 1) begin
        seed_q = lfsr(seed_q);
        fa = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : (i == 2) ? 8'h81 : 8'h90;
        p1 = (i < 3) ? {6'h0, seed_q[1:0]} : (i == 3) ? 8'h00 : 8'h08;
        apb(1'b1, `NFC_REG_FADDR, {24'h0, fa});
        apb(1'b1, `NFC_REG_PARAM, {24'h0, p1});
        op(`NFC_OP_SETF, 8'h00);
        op(`NFC_OP_GETF, 8'h00);
        chk({p1, 24'h0}, r, "feature");
    end
    op(`NFC_OP_RESET, 8'h00);
    op(`NFC_OP_GETF, 8'h00);
    chk(32'h08000000, r, "kept");
    apb(1'b0, `NFC_REG_STAT, 32'h0);
    chk(32'h2, r & 32'h7, "status");
    $display("feature test done");
    op(`NFC_OP_RDPP, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
        op(`NFC_OP_COLCHG, (k == 0) ? 8'd133 : (k == 1) ? 8'd137 : 8'd252);
        for (i = 0; i < 4 + 4 * (k / 2); i = i + 1)
            op(`NFC_OP_RDBYTE, 8'h00);
        e = (k == 0) ? 32'h5802B80B : (k == 1) ? 32'h19006400 : 32'h5A5B5859;
        chk(e, r, "ppage");
    end
    $display("parameter page test done");
    hold_busy <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, `NFC_REG_CTRL, 32'h1);
    apb(1'b0, `NFC_REG_STAT, 32'h0);
    chk(32'h4, r & 32'h7, "refused");
    hold_busy <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `NFC_REG_FADDR, 32'h42);
    op(`NFC_OP_SETF, 8'h00);
    apb(1'b0, `NFC_REG_STAT, 32'h0);
    chk(32'h6, r & 32'h7, "reserved");
    apb(1'b0, 12'h020, 32'h0);
    chk(32'h1, {31'h0, s}, "pslverr");
    $display("refusal test done");
    report_and_stop;
end
initial begin
    repeat (80000) @(posedge pclk);
    n_errors = n_errors + 1;
    report_and_stop;
end
endmodule // testbench
